// [rtl/pio_port_unit.sv]
// Purpose: Over-current enables, flags and interrupt; high-voltage input port registers
// Assumes: APB slave, single clock, detectors and analog path outside
// Notes: Zero-wait-state slave, pready always high
//
// Function
// (RQ1) Reserved addresses read all zeros and ignore writes.
// (RQ2) Detect enable register bits 6,5,4,2,0 switch each channel's detector.
// (RQ3) Bit 2 of enable, irq enable and flags serves the switched supply.
// (RQ4) Interrupt enable register uses the same bit positions.
// (RQ5) Disabled interrupt masks the flag, which is still recorded.
// (RQ6) Detector report sets the matching flag until software clears it.
// (RQ7) Writing one clears a flag; writing zero leaves it.
// (RQ8) Interrupt requested while any flag and its enable are both set.
// (RQ9) High-voltage input register is read-only.
// (RQ10) Input bit returns pin state when digital enabled and ADC link off.
// (RQ11) Otherwise input bit reads one, apart from test override.
// (RQ12) Pull select picks analog-mode pull device for open input detection.
// (RQ13) Pull select zero keeps the divider pulldown active.
// (RQ14) Pullup applies only with select one, test enable one, not stop.
// (RQ15) Unimplemented register bits read zero.
`timescale 1ns/1ps
module pio_port_unit (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pio_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [pio_pkg::DATA_W-1:0] i_pwdata,
   output logic [pio_pkg::DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Over-current detectors
   input wire logic [pio_pkg::REG_W-1:0] i_oc_detect,
   output logic [pio_pkg::REG_W-1:0] o_oc_detector_on,
   output logic o_oc_irq,
   // High-voltage input pins and qualifiers
   input wire logic [pio_pkg::HV_W-1:0] i_hv_pin_sync,
   input wire logic [pio_pkg::HV_W-1:0] i_hv_digital_input_enable,
   input wire logic [pio_pkg::HV_W-1:0] i_hv_adc_link_enable,
   input wire logic [pio_pkg::HV_W-1:0] i_hv_test_enable,
   input wire logic i_stop_mode,
   output logic [pio_pkg::HV_W-1:0] o_hv_pullup_on
);
   import pio_pkg::*;

   logic [REG_W-1:0] det_en_q;
   logic [REG_W-1:0] irq_en_q;
   logic [REG_W-1:0] flags_q;
   logic [HV_W-1:0] pull_q;
   logic [HV_W-1:0] hv_read;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] prdata_q;
   logic wr_acc;
   logic rd_acc;
   logic [REG_W-1:0] clr_mask;
   logic irq_q;
   logic hit_flags;
   logic hit_any;

   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && !i_penable && !i_pwrite;
   // Address hits, used by the flag checks and the checks on reserved locations
   assign hit_flags = (i_paddr == OFF_OC_FLAGS);
   assign hit_any = (i_paddr == OFF_OC_ENABLE) || (i_paddr == OFF_OC_IRQ_EN) || hit_flags
      || (i_paddr == OFF_HV_INPUT) || (i_paddr == OFF_HV_PULL);
   // Zero wait states keep the master simple
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   assign o_prdata = prdata_q;

   // Detector enables
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         det_en_q <= OC_RESET;
      end else if (wr_acc && i_paddr == OFF_OC_ENABLE) begin
         det_en_q <= i_pwdata[REG_W-1:0] & OC_IMPL_MASK; // RQ2 RQ3 RQ15
      end
   end
   assign o_oc_detector_on = det_en_q; // RQ2

   // Interrupt enables
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_en_q <= OC_RESET;
      end else if (wr_acc && i_paddr == OFF_OC_IRQ_EN) begin
         irq_en_q <= i_pwdata[REG_W-1:0] & OC_IMPL_MASK; // RQ4 RQ3
      end
   end

   // Event flags: a detection in the clearing cycle wins over the clear
   assign clr_mask = (wr_acc && i_paddr == OFF_OC_FLAGS) ? i_pwdata[REG_W-1:0] : OC_RESET;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         flags_q <= OC_RESET;
      end else begin
         flags_q <= ((flags_q & ~clr_mask) | i_oc_detect) & OC_IMPL_MASK; // RQ6 RQ7 RQ3
      end
   end

   // Interrupt level; masked flags remain recorded
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & irq_en_q); // RQ5 RQ8
      end
   end
   assign o_oc_irq = irq_q;

   // Pull select
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pull_q <= HV_PULL_RESET;
      end else if (wr_acc && i_paddr == OFF_HV_PULL) begin
         pull_q <= i_pwdata[HV_W-1:0]; // RQ12
      end
   end

   genvar g;
   generate
      for (g = 0; g < HV_W; g++) begin : g_hv
         pio_hv_input u_hv (
            .i_pin_sync(i_hv_pin_sync[g]),
            .i_dig_en(i_hv_digital_input_enable[g]),
            .i_adc_en(i_hv_adc_link_enable[g]),
            .i_test_en(i_hv_test_enable[g]),
            .i_pull_sel(pull_q[g]),
            .i_stop_mode(i_stop_mode),
            .o_read_bit(hv_read[g]),
            .o_pullup_on(o_hv_pullup_on[g]) // RQ14
         );
      end
   endgenerate

   // Read decode; input register has no write path
   always_comb begin
      rdata_d = READ_ZERO;
      case (i_paddr)
         OFF_OC_ENABLE: rdata_d[REG_W-1:0] = det_en_q;
         OFF_OC_IRQ_EN: rdata_d[REG_W-1:0] = irq_en_q;
         OFF_OC_FLAGS: rdata_d[REG_W-1:0] = flags_q;
         OFF_HV_INPUT: rdata_d[HV_W-1:0] = hv_read; // RQ9 RQ15
         OFF_HV_PULL: rdata_d[HV_W-1:0] = pull_q;
         default: rdata_d = READ_ZERO; // RQ1
      endcase
   end

   // Read data captured in the setup cycle, valid through access
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         prdata_q <= READ_ZERO;
      end else if (rd_acc) begin
         prdata_q <= rdata_d;
      end
   end

   // Assertions
   flag_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ6
      (flags_q != OC_RESET && !(wr_acc && hit_flags)) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
      else $error("Flag lost without a clear");
   flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ6
      (i_oc_detect[0]) |=> flags_q[0])
      else $error("Detection not recorded");
   flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ7
      (wr_acc && i_paddr == OFF_OC_FLAGS && i_pwdata[4] && !i_oc_detect[4]) |=> !flags_q[4])
      else $error("Write one did not clear flag");
   irq_level_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ8
      ##1 (o_oc_irq == |($past(flags_q) & $past(irq_en_q))))
      else $error("Interrupt level mismatch");
   mask_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ5
      (irq_en_q == OC_RESET) [*2] |-> !o_oc_irq)
      else $error("Masked flag raised interrupt");
   enable_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ2
      (wr_acc && i_paddr == OFF_OC_ENABLE) |=> (det_en_q == ($past(i_pwdata[REG_W-1:0]) & OC_IMPL_MASK)))
      else $error("Enable write wrong");
   unimpl_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ15
      ((flags_q | det_en_q | irq_en_q) & ~OC_IMPL_MASK) == OC_RESET)
      else $error("Unimplemented bit set");
   reserved_read_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ1
      (rd_acc && !hit_any) |=> (o_prdata == READ_ZERO))
      else $error("Reserved read not zero");
   hv_default_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ11
      (!i_hv_digital_input_enable[0]) |-> hv_read[0])
      else $error("Input bit not one");
   pullup_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ14
      (o_hv_pullup_on[1]) |-> (pull_q[1] && i_hv_test_enable[1] && !i_stop_mode))
      else $error("Pullup without conditions");

   // Register writes, supply flag set, read-only and reserved locations
   irq_en_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ4
      (wr_acc && i_paddr == OFF_OC_IRQ_EN) |=> (irq_en_q == ($past(i_pwdata[REG_W-1:0]) & OC_IMPL_MASK)))
      else $error("Interrupt enable write wrong");
   pull_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ12
      (wr_acc && i_paddr == OFF_HV_PULL) |=> (pull_q == $past(i_pwdata[HV_W-1:0])))
      else $error("Pull select write wrong");
   supply_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ3
      i_oc_detect[OC_SUPPLY_BIT] |=> flags_q[OC_SUPPLY_BIT])
      else $error("Supply detection not recorded");
   zero_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ7
      (wr_acc && hit_flags && i_pwdata[REG_W-1:0] == OC_RESET) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
      else $error("Zero write changed a flag");
   hv_readonly_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ9
      (wr_acc && i_paddr == OFF_HV_INPUT) |=> ($stable(det_en_q) && $stable(irq_en_q) && $stable(pull_q)))
      else $error("Input register write had an effect");
   reserved_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ1
      (wr_acc && !hit_any) |=> ($stable(det_en_q) && $stable(irq_en_q) && $stable(pull_q)
         && ((flags_q & $past(flags_q)) == $past(flags_q))))
      else $error("Reserved write had an effect");
   read_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      rd_acc |=> (o_prdata == $past(rdata_d)))
      else $error("Read data not captured");
   // Reset is synchronous, so state is checked one edge later
   reset_state_a: assert property (@(posedge i_ref_clk)
      i_sys_rst |=> (det_en_q == OC_RESET && irq_en_q == OC_RESET && flags_q == OC_RESET
         && pull_q == HV_PULL_RESET && !o_oc_irq && o_prdata == READ_ZERO))
      else $error("State not cleared by reset");

   // Per-channel checks; unimplemented positions must stay zero
   genvar c;
   generate
      for (c = 0; c < REG_W; c++) begin : g_oc_chk
         if (OC_IMPL_MASK[c]) begin : g_impl
            chan_set_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ6
               i_oc_detect[c] |=> flags_q[c])
               else $error("Channel detection not recorded");
            chan_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ7
               (wr_acc && hit_flags && i_pwdata[c] && !i_oc_detect[c]) |=> !flags_q[c])
               else $error("Channel flag not cleared");
            chan_irq_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ8
               (flags_q[c] && irq_en_q[c]) |=> o_oc_irq)
               else $error("Enabled flag gave no interrupt");
            chan_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ5
               (flags_q[c] && !irq_en_q[c] && !(wr_acc && hit_flags && i_pwdata[c])) |=> flags_q[c])
               else $error("Masked flag not kept");
         end else begin : g_unimpl
            chan_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ15
               (!flags_q[c] && !det_en_q[c] && !irq_en_q[c]))
               else $error("Unimplemented channel bit set");
         end
      end
   endgenerate

   // Per-pin checks of the high-voltage input path
   genvar h;
   generate
      for (h = 0; h < HV_W; h++) begin : g_hv_chk
         hv_digital_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ10
            (i_hv_digital_input_enable[h] && !i_hv_adc_link_enable[h])
               |-> (hv_read[h] == i_hv_pin_sync[h]))
            else $error("Digital input not passed");
         hv_analog_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ11
            (!i_hv_digital_input_enable[h] || (i_hv_adc_link_enable[h] && !i_hv_test_enable[h]))
               |-> hv_read[h])
            else $error("Input bit not one");
         hv_override_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ11
            (i_hv_digital_input_enable[h] && i_hv_test_enable[h]) |-> (hv_read[h] == i_hv_pin_sync[h]))
            else $error("Test override not applied");
         pulldown_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ13
            !pull_q[h] |-> !o_hv_pullup_on[h])
            else $error("Pullup with select zero");
         pullup_on_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ14
            (pull_q[h] && i_hv_test_enable[h] && !i_stop_mode) |-> o_hv_pullup_on[h])
            else $error("Pullup missing");
      end
   endgenerate

   irq_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(o_oc_irq));
   supply_flag_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(flags_q[OC_SUPPLY_BIT]));
   clear_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $fell(flags_q[0]));
   pullup_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) o_hv_pullup_on[0]);
   set_wins_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      wr_acc && hit_flags && ((i_pwdata[REG_W-1:0] & i_oc_detect) != OC_RESET));
endmodule

// [rtl/pio_pkg.sv]
// Purpose: Constants for the port over-current and high-voltage input block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
package pio_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int REG_W = 8;
   localparam int HV_W = 2;
   localparam logic [ADDR_W-1:0] OFF_OC_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_OC_IRQ_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_OC_FLAGS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_HV_INPUT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_HV_PULL = 8'h10;
   // Protected channel bits: pins 6, 5, 4, 0 and the switched supply at 2
   localparam logic [REG_W-1:0] OC_IMPL_MASK = 8'h75;
   localparam int OC_SUPPLY_BIT = 2;
   localparam logic [REG_W-1:0] OC_RESET = 8'h00;
   localparam logic [HV_W-1:0] HV_PULL_RESET = 2'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// [rtl/pio_hv_input.sv]
// Purpose: Read value and pull steering of one high-voltage input pin
// Assumes: Pin state already synchronised
// Notes: Pure combinational slice
`timescale 1ns/1ps
module pio_hv_input (
   // Pin and configuration
   input wire logic i_pin_sync,
   input wire logic i_dig_en,
   input wire logic i_adc_en,
   input wire logic i_test_en,
   input wire logic i_pull_sel,
   input wire logic i_stop_mode,
   // Results
   output logic o_read_bit,
   output logic o_pullup_on
);
   // Test enable keeps the buffer on with the ADC link on, provided digital input is enabled
   always_comb begin
      if ((i_dig_en && !i_adc_en) || (i_dig_en && i_test_en)) begin
         o_read_bit = i_pin_sync; // RQ10
      end else begin
         o_read_bit = 1'b1; // RQ11
      end
   end
   // Pulldown of the divider stays unless all three conditions hold
   assign o_pullup_on = i_pull_sel && i_test_en && !i_stop_mode; // RQ13 RQ14
endmodule

// [testbench/pio_port_unit_tb_top.sv]
// Purpose: Self-checking bench for the over-current and high-voltage input registers
// Assumes: Zero-wait APB slave, offsets from pio_pkg
// Notes: A detection takes two cycles to reach the interrupt line, a set flag one
`timescale 1ns/1ps
module pio_port_unit_tb_top;
   import pio_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, stop = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, irq;
   logic [REG_W-1:0] det = '0, det_on;
   logic [HV_W-1:0] pin = '0, dig = '0, adc = '0, ten = '0, pup;
   int n_fail = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   pio_port_unit u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_oc_detect(det), .o_oc_detector_on(det_on), .o_oc_irq(irq), .i_hv_pin_sync(pin),
      .i_hv_digital_input_enable(dig), .i_hv_adc_link_enable(adc), .i_hv_test_enable(ten),
      .i_stop_mode(stop), .o_hv_pullup_on(pup));
   task automatic final_report();
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // Master holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         final_report();
      end else begin
         rd = prdata;
         psel <= 1'b0;
         pen <= 1'b0;
         // Idle edge, so a following call never reassigns psel in this time step
         @(posedge clk);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic s_reset();
      rchk("enable", OFF_OC_ENABLE, 32'h0);
      rchk("irq_en", OFF_OC_IRQ_EN, 32'h0);
      rchk("flags", OFF_OC_FLAGS, 32'h0);
      rchk("pull", OFF_HV_PULL, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
   endtask
   task automatic s_regs();
      apb(1'b1, OFF_OC_ENABLE, 32'hffff_ffff);
      rchk("enable", OFF_OC_ENABLE, 32'h75);
      chk("det_on", 32'h75, {24'h0, det_on});
      apb(1'b1, OFF_OC_ENABLE, 32'h04);
      rchk("enable", OFF_OC_ENABLE, 32'h04);
      chk("det_on", 32'h04, {24'h0, det_on});
      apb(1'b1, OFF_OC_IRQ_EN, 32'hffff_ffff);
      rchk("irq_en", OFF_OC_IRQ_EN, 32'h75);
      apb(1'b1, OFF_OC_IRQ_EN, 32'h8a);
      rchk("irq_en", OFF_OC_IRQ_EN, 32'h0);
   endtask
   task automatic s_flags();
      det <= 8'hff;
      @(posedge clk);
      det <= 8'h00;
      repeat (3) @(posedge clk);
      rchk("flags", OFF_OC_FLAGS, 32'h75);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, OFF_OC_IRQ_EN, 32'h04);
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, OFF_OC_FLAGS, 32'h0);
      rchk("flags", OFF_OC_FLAGS, 32'h75);
      apb(1'b1, OFF_OC_FLAGS, 32'h04);
      repeat (3) @(posedge clk);
      rchk("flags", OFF_OC_FLAGS, 32'h71);
      chk("irq", 32'h0, {31'h0, irq});
      // Detection only at the clearing edge, so a lost set would show
      fork
         apb(1'b1, OFF_OC_FLAGS, 32'h01);
         begin
            @(posedge clk);
            det <= 8'h01;
            @(posedge clk);
            det <= 8'h00;
         end
      join
      rchk("flags", OFF_OC_FLAGS, 32'h71);
      apb(1'b1, OFF_OC_FLAGS, 32'h75);
      rchk("flags", OFF_OC_FLAGS, 32'h0);
   endtask
   task automatic s_reserved();
      apb(1'b1, 8'h14, 32'hffff_ffff);
      rchk("reserved", 8'h14, 32'h0);
      rchk("enable", OFF_OC_ENABLE, 32'h04);
      chk("pslverr", 32'h0, {31'h0, pslverr});
      dig <= 2'b11;
      adc <= 2'b00;
      pin <= 2'b01;
      apb(1'b1, OFF_HV_INPUT, 32'h2);
      rchk("hv_input", OFF_HV_INPUT, 32'h1);
   endtask
   task automatic s_hv();
      for (int i = 0; i < 4; i++) begin
         dig <= {2{i[0]}}; adc <= {2{i[1]}}; pin <= 2'b01;
         rchk("hv_input", OFF_HV_INPUT, (i == 1) ? 32'h1 : 32'h3);
      end
      ten <= 2'b11;
      rchk("hv_input", OFF_HV_INPUT, 32'h1);
      apb(1'b1, OFF_HV_PULL, 32'hffff_ffff);
      rchk("pull", OFF_HV_PULL, 32'h3);
      ten <= 2'b01;
      @(posedge clk);
      chk("pullup", 32'h1, {30'h0, pup});
      stop <= 1'b1;
      @(posedge clk);
      chk("pullup", 32'h0, {30'h0, pup});
      stop <= 1'b0; ten <= 2'b11;
      apb(1'b1, OFF_HV_PULL, 32'h2);
      @(posedge clk);
      chk("pullup", 32'h2, {30'h0, pup});
   endtask
   task automatic s_midreset();
      apb(1'b1, OFF_OC_IRQ_EN, 32'h01);
      det <= 8'h01;
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      det <= 8'h00;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      chk("det_on", 32'h0, {24'h0, det_on});
      chk("pullup", 32'h0, {30'h0, pup});
      rchk("irq_en", OFF_OC_IRQ_EN, 32'h0);
      rchk("flags", OFF_OC_FLAGS, 32'h0);
      rchk("pull", OFF_HV_PULL, 32'h0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_reset();
      s_regs();
      s_flags();
      s_reserved();
      s_hv();
      s_midreset();
      final_report();
   end
endmodule
